// *** design/cwd_config_decoder.sv ***
// configuration word store, decode and program memory access gating
`timescale 1ns/100ps
`default_nettype none
`include "cwd_defines.svh"

// Notes on behaviour
// RULE1 - config words live at 8007h and 8008h
// RULE2 - bit 13 one enables clock fail monitor
// RULE3 - bit 12 one enables two-speed switchover
// RULE4 - clock-output bit low drives instruction clock
// RULE5 - brown-out field: always, run, software, off
// RULE6 - unimplemented config bits always read one
// RULE7 - code protect sticks until bulk erase
// RULE8 - protected: tool access blocked, reads zero
// RULE9 - reset-pin bit ignored while low-voltage programming
// RULE10 - power-up timer bit active low, independent
// RULE11 - watchdog field: always, run, software, off
// RULE12 - three-bit field picks the oscillator mode
// RULE13 - low-voltage bit cannot clear during entry
// RULE14 - debug bit low dedicates serial pins
// RULE15 - low-power brown-out active low, trip select
// RULE16 - stack fault resets when bit set
// RULE17 - pll enable, factor three or four
// RULE18 - usb clock divides by eight or four
// RULE19 - cpu divider six, three, two, one
// RULE20 - self-write field blocks low address ranges
// RULE21 - four user_ident_word0 words read/write
// RULE22 - device and revision IDs at 8005h/8006h
// RULE23 - identity words are fourteen-bit read-only
// RULE24 - words sampled at reset, settings held static
module cwd_config_decoder
#(
    // identity codes: arbitrary neutral values
    parameter logic [13:0] PART_IDENTITY = 14'h0A5A,
    parameter logic [13:0] SILICON_REVISION = 14'h0001
)
(
    // clock, reset, enable
    input wire logic MCLK_I,
    input wire logic RESETN_I,
    input wire logic CE_I,
    // register port
    input wire cwd_pkg::cwd_req_t REQ_I,
    output logic [13:0] RDATA_O,
    // nonvolatile cell contents and tool controls
    input wire logic [13:0] NV_CFG1_I,
    input wire logic [13:0] NV_CFG2_I,
    input wire logic BULK_ERASE_I,
    input wire logic LVP_ENTRY_I,
    // program memory side
    input wire logic [13:0] PM_RDATA_I,
    output logic [14:0] PM_ADDR_O,
    output logic [13:0] PM_WDATA_O,
    output logic PM_WR_O,
    // decoded settings
    output cwd_pkg::cwd_settings_t SETTINGS_O,
    output logic LOADED_O
);
    import cwd_pkg::*;

    // stored words: the two config images and the user IDs
    logic [13:0] cfg1_reg;
    logic [13:0] cfg1_next;
    logic [13:0] cfg2_reg;
    logic [13:0] cfg2_next;
    logic [13:0] user_ident_word0_reg [`CWD_UID_COUNT];
    // load pending until the first enabled edge after reset
    logic load_pend_reg;
    // loaded flag kept in its own flop so the output needs no inverter
    logic loaded_reg;
    // static decoded settings
    cwd_settings_t settings_reg;
    cwd_settings_t settings_next;
    // bus answer and memory strobe
    logic [13:0] rdata_reg;
    logic [13:0] rdata_next;
    logic pm_wr_reg;
    logic pm_wr_next;
    logic [14:0] pm_addr_reg;
    logic [13:0] pm_wdata_reg;

    // address decode
    logic in_cfg_space;
    logic hit_uid;
    logic hit_devid;
    logic hit_revid;
    logic hit_cfg1;
    logic hit_cfg2;
    logic [`CWD_UID_IDX_W-1:0] uid_idx;
    logic [`CWD_UID_COUNT-1:0] uid_wr;

    // words seen by the decoder: fresh cells on load, image otherwise
    logic [13:0] src1;
    logic [13:0] src2;
    // guard verdicts
    logic pm_wr_ok;
    logic pm_rd_zero;

    // upper half of the space is configuration, lower is program memory
    assign in_cfg_space = REQ_I.addr[`CWD_SPACE_BIT];
    assign hit_uid = (REQ_I.addr >= `CWD_UID_BASE) &&
                     (REQ_I.addr < 16'(`CWD_UID_BASE + `CWD_UID_COUNT));
    assign uid_idx = REQ_I.addr[`CWD_UID_IDX_W-1:0];
    // RULE22 identity locations
    assign hit_devid = (REQ_I.addr == `CWD_DEVID_ADDR);
    assign hit_revid = (REQ_I.addr == `CWD_REVID_ADDR);
    // RULE1 config locations
    assign hit_cfg1 = (REQ_I.addr == `CWD_CFG1_ADDR);
    assign hit_cfg2 = (REQ_I.addr == `CWD_CFG2_ADDR);

    // RULE6 force unused bits
    assign src1 = (load_pend_reg ? NV_CFG1_I : cfg1_reg) | `CWD_CFG1_FORCE1;
    assign src2 = (load_pend_reg ? NV_CFG2_I : cfg2_reg) | `CWD_CFG2_FORCE1;

    // protection checks for program memory accesses
    cwd_write_guard u_guard
    (
        .addr_i(REQ_I.addr),
        .ext_i(REQ_I.ext),
        .protect_on_i(settings_reg.code_protect_on),
        .wrt_field_i(settings_reg.self_write_protect_field),
        .wr_ok_o(pm_wr_ok),
        .rd_zero_o(pm_rd_zero)
    );

    // first word decode
    // RULE2 monitor enable
    assign settings_next.clock_fail_monitor_en = src1[`CWD_B_FAILMON];
    // RULE3 switchover enable
    assign settings_next.two_speed_switchover_en = src1[`CWD_B_SWITCHOVER];
    // RULE4 active-low clock out
    assign settings_next.clock_out_drive = !src1[`CWD_B_CLKOUT_N];
    // RULE5 brown-out mode
    assign settings_next.brownout_mode = cwd_sup_t'(src1[`CWD_F_BROWNOUT]);
    // RULE7 active-low protect
    assign settings_next.code_protect_on = !src1[`CWD_B_PROTECT_N];
    // RULE9 pin stays reset under low-voltage programming
    assign settings_next.reset_pin_is_reset = src2[`CWD_B_LOWVOLT] |
                                              src1[`CWD_B_RSTPIN];
    // RULE10 timer own bit only
    assign settings_next.powerup_timer_on = !src1[`CWD_B_PWRUP_N];
    // RULE11 watchdog mode
    assign settings_next.watchdog_mode = cwd_sup_t'(src1[`CWD_F_WATCHDOG]);
    // RULE12 oscillator mode
    assign settings_next.osc_sel = cwd_osc_t'(src1[`CWD_F_OSC]);

    // second word decode
    // RULE13 programming mode flag
    assign settings_next.low_voltage_prog_en = src2[`CWD_B_LOWVOLT];
    // RULE14 debugger when low
    assign settings_next.debugger_on = !src2[`CWD_B_DEBUG_N];
    // RULE15 low-power brown-out, trip
    assign settings_next.low_power_brownout_on = !src2[`CWD_B_LPBROWN_N];
    assign settings_next.brownout_trip_low = src2[`CWD_B_TRIP];
    // RULE16 stack fault reset
    assign settings_next.stack_fault_reset_en = src2[`CWD_B_STACKRST];
    // RULE17 pll enable, factor
    assign settings_next.pll_on = src2[`CWD_B_PLL_ON];
    assign settings_next.pll_factor = src2[`CWD_B_PLL_FACTOR] ?
                                      `CWD_PLL_X3 : `CWD_PLL_X4;
    // RULE18 usb divider
    assign settings_next.usb_clock_div = src2[`CWD_B_USB_SLOW] ?
                                         `CWD_USB_DIV8 : `CWD_USB_DIV4;
    // RULE19 cpu divider
    assign settings_next.cpu_clock_div =
        (src2[`CWD_F_CPU_CLOCK_DIVIDER] == 2'h3) ? `CWD_CPU_CLOCK_DIVIDER_11 :
        (src2[`CWD_F_CPU_CLOCK_DIVIDER] == 2'h2) ? `CWD_CPU_CLOCK_DIVIDER_10 :
        (src2[`CWD_F_CPU_CLOCK_DIVIDER] == 2'h1) ? `CWD_CPU_CLOCK_DIVIDER_01 :
        `CWD_CPU_CLOCK_DIVIDER_00;
    // RULE20 field kept for guard
    assign settings_next.self_write_protect_field = src2[`CWD_F_SELFWR];

    // tool writes to the config images; the cpu cannot change them
    logic cfg_wr_ok;
    assign cfg_wr_ok = REQ_I.wr && REQ_I.ext && !load_pend_reg;

    // RULE7 protect bit only clears
    // RULE6 unused bits stay one
    assign cfg1_next = BULK_ERASE_I ? `CWD_ERASED :
        (cfg_wr_ok && hit_cfg1) ?
            ({REQ_I.wdata[13:8], REQ_I.wdata[7] & cfg1_reg[7],
              REQ_I.wdata[6:0]} | `CWD_CFG1_FORCE1) :
        cfg1_reg;

    // RULE13 refuse clearing during entry
    assign cfg2_next = BULK_ERASE_I ? `CWD_ERASED :
        (cfg_wr_ok && hit_cfg2) ?
            ({REQ_I.wdata[13] | (LVP_ENTRY_I & cfg2_reg[13]),
              REQ_I.wdata[12:0]} | `CWD_CFG2_FORCE1) :
        cfg2_reg;

    // RULE8 tool reads of memory zeroed
    // RULE23 identity fourteen bits
    // RULE21 user_ident_word0 readback
    assign rdata_next =
        !REQ_I.rd ? `CWD_ZERO_WORD :
        !in_cfg_space ? (pm_rd_zero ? `CWD_ZERO_WORD : PM_RDATA_I) :
        hit_uid ? user_ident_word0_reg[uid_idx] :
        hit_devid ? PART_IDENTITY :
        hit_revid ? SILICON_REVISION :
        hit_cfg1 ? cfg1_reg :
        hit_cfg2 ? cfg2_reg :
        `CWD_ZERO_WORD;

    // RULE20 guarded memory write
    assign pm_wr_next = REQ_I.wr && !in_cfg_space && pm_wr_ok &&
                        !load_pend_reg;

    // load flag: held until the first enabled edge after reset
    always_ff @(posedge MCLK_I or negedge RESETN_I)
    begin
        if (!RESETN_I)
        begin
            load_pend_reg <= 1'b1;
            loaded_reg <= 1'b0;
        end
        else if (CE_I)
        begin
            load_pend_reg <= 1'b0;
            loaded_reg <= 1'b1;
        end
    end

    // config images: cells caught on load, then tool writes and erase
    always_ff @(posedge MCLK_I or negedge RESETN_I)
    begin
        if (!RESETN_I)
        begin
            cfg1_reg <= `CWD_ERASED;
            cfg2_reg <= `CWD_ERASED;
        end
        else if (CE_I)
        begin
            // RULE24 catch cells once
            cfg1_reg <= load_pend_reg ? src1 : cfg1_next;
            cfg2_reg <= load_pend_reg ? src2 : cfg2_next;
        end
    end

    // static settings, only refreshed on the load edge so a tool
    // write never changes clocking or protection mid-run
    always_ff @(posedge MCLK_I or negedge RESETN_I)
    begin
        if (!RESETN_I)
            settings_reg <= '0;
        // RULE24 hold until reset
        else if (CE_I && load_pend_reg)
            settings_reg <= settings_next;
    end

    // user_ident_word0 words, one writer per entry
    genvar g;
    generate
        for (g = 0; g < `CWD_UID_COUNT; g++)
        begin : g_uid
            // one-hot write select for this entry
            assign uid_wr[g] = REQ_I.wr && hit_uid &&
                               (uid_idx == `CWD_UID_IDX_W'(g));
            // RULE21 cpu or tool write
            always_ff @(posedge MCLK_I or negedge RESETN_I)
            begin
                if (!RESETN_I)
                    user_ident_word0_reg[g] <= `CWD_ERASED;
                else if (CE_I)
                begin
                    // erase wins over a write in the same cycle
                    if (BULK_ERASE_I)
                        user_ident_word0_reg[g] <= `CWD_ERASED;
                    else if (uid_wr[g])
                        user_ident_word0_reg[g] <= REQ_I.wdata;
                end
            end
        end
    endgenerate

    // read answer, valid in the cycle after the strobe only
    always_ff @(posedge MCLK_I or negedge RESETN_I)
    begin
        if (!RESETN_I)
            rdata_reg <= `CWD_ZERO_WORD;
        else if (CE_I)
            rdata_reg <= rdata_next;
    end

    // program memory write strobe with its address and data
    always_ff @(posedge MCLK_I or negedge RESETN_I)
    begin
        if (!RESETN_I)
        begin
            pm_wr_reg <= 1'b0;
            pm_addr_reg <= '0;
            pm_wdata_reg <= `CWD_ZERO_WORD;
        end
        else if (CE_I)
        begin
            pm_wr_reg <= pm_wr_next;
            // address and data only move with a granted write
            if (pm_wr_next)
            begin
                pm_addr_reg <= REQ_I.addr[14:0];
                pm_wdata_reg <= REQ_I.wdata;
            end
        end
    end

    // outputs straight from flops
    assign RDATA_O = rdata_reg;
    assign PM_WR_O = pm_wr_reg;
    assign PM_ADDR_O = pm_addr_reg;
    assign PM_WDATA_O = pm_wdata_reg;
    assign SETTINGS_O = settings_reg;
    assign LOADED_O = loaded_reg;
endmodule
`default_nettype wire

// *** design/cwd_write_guard.sv ***
// program memory access guard: code protect and self-write ranges
`timescale 1ns/100ps
`default_nettype none
`include "cwd_defines.svh"
module cwd_write_guard
(
    // access under test
    input wire logic [15:0] addr_i,
    input wire logic ext_i,
    // static protection settings
    input wire logic protect_on_i,
    input wire logic [1:0] wrt_field_i,
    // verdicts
    output logic wr_ok_o,
    output logic rd_zero_o
);
    // top address of the blocked range, per field code
    logic [15:0] wrt_limit;
    logic cpu_blocked;
    // RULE20 range decode
    assign wrt_limit = (wrt_field_i == `CWD_WRT_SMALL) ? `CWD_WRT_LIM_SMALL :
                       (wrt_field_i == `CWD_WRT_HALF) ? `CWD_WRT_LIM_HALF :
                       `CWD_WRT_LIM_ALL;
    // RULE20 block low range
    assign cpu_blocked = (wrt_field_i != `CWD_WRT_NONE) && (addr_i <= wrt_limit);
    // RULE8 tool access gated
    assign wr_ok_o = ext_i ? !protect_on_i : !cpu_blocked;
    // RULE8 tool reads zero
    assign rd_zero_o = ext_i && protect_on_i;
endmodule
`default_nettype wire

// *** inc/cwd_defines.svh ***
// addresses, field positions, reset values and divide figures
`ifndef CWD_DEFINES_SVH
`define CWD_DEFINES_SVH
// configuration space locations
`define CWD_UID_BASE 16'h8000
`define CWD_UID_COUNT 4
`define CWD_UID_IDX_W 2
`define CWD_DEVID_ADDR 16'h8005
`define CWD_REVID_ADDR 16'h8006
`define CWD_CFG1_ADDR 16'h8007
`define CWD_CFG2_ADDR 16'h8008
`define CWD_SPACE_BIT 15
// word width and erased value
`define CWD_WORD_W 14
`define CWD_ADDR_W 16
`define CWD_ERASED 14'h3FFF
`define CWD_ZERO_WORD 14'h0000
// unimplemented bits forced to one
`define CWD_CFG1_FORCE1 14'h0100
`define CWD_CFG2_FORCE1 14'h000C
// first word fields
`define CWD_B_FAILMON 13
`define CWD_B_SWITCHOVER 12
`define CWD_B_CLKOUT_N 11
`define CWD_F_BROWNOUT 10:9
`define CWD_B_PROTECT_N 7
`define CWD_B_RSTPIN 6
`define CWD_B_PWRUP_N 5
`define CWD_F_WATCHDOG 4:3
`define CWD_F_OSC 2:0
// second word fields
`define CWD_B_LOWVOLT 13
`define CWD_B_DEBUG_N 12
`define CWD_B_LPBROWN_N 11
`define CWD_B_TRIP 10
`define CWD_B_STACKRST 9
`define CWD_B_PLL_ON 8
`define CWD_B_PLL_FACTOR 7
`define CWD_B_USB_SLOW 6
`define CWD_F_CPU_CLOCK_DIVIDER 5:4
`define CWD_F_SELFWR 1:0
// divide and multiply figures
`define CWD_PLL_X3 3'h3
`define CWD_PLL_X4 3'h4
`define CWD_USB_DIV8 4'h8
`define CWD_USB_DIV4 4'h4
`define CWD_CPU_CLOCK_DIVIDER_11 3'h6
`define CWD_CPU_CLOCK_DIVIDER_10 3'h3
`define CWD_CPU_CLOCK_DIVIDER_01 3'h2
`define CWD_CPU_CLOCK_DIVIDER_00 3'h1
// self-write protect field codes and top addresses
`define CWD_WRT_NONE 2'h3
`define CWD_WRT_SMALL 2'h2
`define CWD_WRT_HALF 2'h1
`define CWD_WRT_LIM_SMALL 16'h01FF
`define CWD_WRT_LIM_HALF 16'h0FFF
`define CWD_WRT_LIM_ALL 16'h1FFF
`endif

// *** inc/cwd_pkg.sv ***
// types shared by the configuration word decoder
package cwd_pkg;
    // oscillator select, in field code order
    typedef enum logic [2:0] {
        OSC_WATCH_CRYSTAL_MODE,
        OSC_CRYSTAL_MEDIUM_GAIN,
        OSC_HIGH_GAIN_CRYSTAL,
        OSC_RESISTOR_CAPACITOR,
        OSC_INTERNAL_OSCILLATOR,
        OSC_EXT_CLOCK_LOW_POWER,
        OSC_EXT_CLOCK_MEDIUM_POWER,
        OSC_EXT_CLOCK_HIGH_POWER
    } cwd_osc_t;
    // brown-out and watchdog modes, in field code order
    typedef enum logic [1:0] {
        SUPERVISOR_OFF, SUPERVISOR_BY_SW, SUPERVISOR_RUN_ONLY, SUPERVISOR_ALWAYS
    } cwd_sup_t;
    // register port request
    typedef struct packed {
        logic [15:0] addr;
        logic [13:0] wdata;
        logic wr;
        logic rd;
        logic ext;
    } cwd_req_t;
    // decoded static settings
    typedef struct packed {
        logic clock_fail_monitor_en;
        logic two_speed_switchover_en;
        logic clock_out_drive;
        cwd_sup_t brownout_mode;
        logic code_protect_on;
        logic reset_pin_is_reset;
        logic powerup_timer_on;
        cwd_sup_t watchdog_mode;
        cwd_osc_t osc_sel;
        logic low_voltage_prog_en;
        logic debugger_on;
        logic low_power_brownout_on;
        logic brownout_trip_low;
        logic stack_fault_reset_en;
        logic pll_on;
        logic [2:0] pll_factor;
        logic [3:0] usb_clock_div;
        logic [2:0] cpu_clock_div;
        logic [1:0] self_write_protect_field;
    } cwd_settings_t;
endpackage

// *** tb/cwd_config_decoder_asserts.sv ***
// port checker for the configuration word decoder
`timescale 1ns/100ps
`default_nettype none
module cwd_config_decoder_asserts
#(
    parameter logic [13:0] PART_IDENTITY = 14'h0000
)
(
    // clock and reset
    input wire logic MCLK_I,
    input wire logic RESETN_I,
    input wire logic CE_I,
    // register port
    input wire cwd_pkg::cwd_req_t REQ_I,
    input wire logic [13:0] RDATA_O,
    // program memory side
    input wire logic [14:0] PM_ADDR_O,
    input wire logic PM_WR_O,
    // decoded settings
    input wire cwd_pkg::cwd_settings_t SETTINGS_O,
    input wire logic LOADED_O
);
    import cwd_pkg::*;
    // request taken at this edge
    logic take;
    // read and write strobes qualified by the take condition
    logic rd_t;
    logic wr_t;
    // program memory write request and its low address
    logic wr_pm;
    logic [14:0] req_lo;
    // protection as loaded, used by several checks
    logic prot;
    assign take = CE_I && LOADED_O;
    assign rd_t = take && REQ_I.rd;
    assign wr_t = take && REQ_I.wr;
    assign wr_pm = REQ_I.wr && !REQ_I.addr[15];
    assign req_lo = REQ_I.addr[14:0];
    assign prot = SETTINGS_O.code_protect_on;
    default clocking cb @(posedge MCLK_I); endclocking
    default disable iff (!RESETN_I);
    property p_cfg1_spare; rd_t && REQ_I.addr == 16'h8007 |=> RDATA_O[8]; endproperty
    a_cfg1_spare: assert property (p_cfg1_spare) else $error("word one spare bit low");
    property p_cfg2_spare; rd_t && REQ_I.addr == 16'h8008 |=> RDATA_O[3:2] == 2'h3; endproperty
    a_cfg2_spare: assert property (p_cfg2_spare) else $error("word two spare bits low");
    property p_part_id;
        rd_t && REQ_I.addr == 16'h8005 |=> RDATA_O == PART_IDENTITY;
    endproperty
    a_part_id: assert property (p_part_id) else $error("identity word wrong");
    property p_unmapped; rd_t && REQ_I.addr == 16'h8004 |=> RDATA_O == 14'h0000; endproperty
    a_unmapped: assert property (p_unmapped) else $error("gap location not zero");
    property p_static; LOADED_O && $past(LOADED_O) |-> $stable(SETTINGS_O); endproperty
    a_static: assert property (p_static) else $error("settings moved after load");
    property p_pm_src; PM_WR_O |-> $past(wr_pm) && PM_ADDR_O == $past(req_lo); endproperty
    a_pm_src: assert property (p_pm_src) else $error("memory write without request");
    property p_ext_wr; wr_t && REQ_I.ext && prot |=> !PM_WR_O; endproperty
    a_ext_wr: assert property (p_ext_wr) else $error("protected tool write passed");
    property p_ext_rd;
        rd_t && REQ_I.ext && prot && !REQ_I.addr[15] |=> RDATA_O == 14'h0000;
    endproperty
    a_ext_rd: assert property (p_ext_rd) else $error("protected tool read not zero");
    property p_self_wr;
        wr_t && !REQ_I.ext && SETTINGS_O.self_write_protect_field == 2'h0
            && REQ_I.addr <= 16'h1FFF |=> !PM_WR_O;
    endproperty
    a_self_wr: assert property (p_self_wr) else $error("blocked self-write passed");
    // pin bit ignored under low voltage
    property p_lvp_pin; LOADED_O && SETTINGS_O.low_voltage_prog_en |-> SETTINGS_O.reset_pin_is_reset;
    endproperty
    a_lvp_pin: assert property (p_lvp_pin) else $error("reset pin not reset function");
    // main scenarios reached
    c_pm_wr: cover property (PM_WR_O);
    c_prot: cover property (LOADED_O && prot);
    c_cfg_rd: cover property (rd_t && REQ_I.addr == 16'h8007);
endmodule
bind cwd_config_decoder cwd_config_decoder_asserts #(.PART_IDENTITY(PART_IDENTITY)) u_chk (
    .MCLK_I(MCLK_I), .RESETN_I(RESETN_I), .CE_I(CE_I), .REQ_I(REQ_I), .RDATA_O(RDATA_O),
    .PM_ADDR_O(PM_ADDR_O), .PM_WR_O(PM_WR_O), .SETTINGS_O(SETTINGS_O), .LOADED_O(LOADED_O));
`default_nettype wire

// *** tb/cwd_pm_model.sv ***
// program memory stand-in answering reads with an address pattern
`timescale 1ns/100ps
`default_nettype none
module cwd_pm_model
(
    // address from the request port
    input wire logic [14:0] addr_i,
    // read data back to the decoder
    output logic [13:0] rdata_o
);
    // pattern differs per address in bits 13:0 so a stale word shows up
    assign rdata_o = addr_i[13:0] ^ 14'h1ACE;
endmodule
`default_nettype wire

// *** tb/test_config_word_decoder.sv ***
// self-checking bench for the configuration word decoder
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin num_errors++; \
    $display("BAD %0t got %h exp %h", $time, g, e); end end
module test_config_word_decoder;
    import cwd_pkg::*;
    localparam logic [13:0] PART = 14'h1234; // arbitrary identity value
    localparam logic [13:0] REV = 14'h0002; // arbitrary revision value
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    cwd_req_t req = '0;
    logic [13:0] nv1 = 14'h3FFF;
    logic [13:0] nv2 = 14'h3FFF;
    logic erase = 1'b0;
    logic lvp_entry = 1'b0;
    logic ce = 1'b1;
    logic [13:0] rdata, pm_rdata, pm_wdata;
    logic [14:0] pm_addr;
    logic pm_wr, loaded;
    cwd_settings_t settings;
    int num_errors = 0;
    int samples_checked = 0;
    int cycles = 0;
    logic [31:0] seed = 32'h2ef6_7e2d;
    // reference images of the stored words
    logic [13:0] img1, img2;
    logic [13:0] uid[4];
    cwd_config_decoder #(.PART_IDENTITY(PART), .SILICON_REVISION(REV)) dut (
        .MCLK_I(clk), .RESETN_I(rst_n), .CE_I(ce), .REQ_I(req), .RDATA_O(rdata),
        .NV_CFG1_I(nv1), .NV_CFG2_I(nv2), .BULK_ERASE_I(erase), .LVP_ENTRY_I(lvp_entry),
        .PM_RDATA_I(pm_rdata), .PM_ADDR_O(pm_addr), .PM_WDATA_O(pm_wdata), .PM_WR_O(pm_wr),
        .SETTINGS_O(settings), .LOADED_O(loaded));
    cwd_pm_model pm (.addr_i(req.addr[14:0]), .rdata_o(pm_rdata));
    initial
    begin
        forever #4 clk = ~clk;
    end
    // hang guard: far above the few hundred cycles needed
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 8000)
        begin
            num_errors++;
            print_verdict;
        end
    end
    task automatic print_verdict;
        if (num_errors == 0 && samples_checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    function automatic logic [13:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[13:0];
    endfunction
    function automatic logic [13:0] pm_val(input logic [14:0] a);
        return a[13:0] ^ 14'h1ACE;
    endfunction
    // decode written straight from the bit meanings
    function automatic cwd_settings_t exp_set(input logic [13:0] a, input logic [13:0] b);
        cwd_settings_t s;
        s.clock_fail_monitor_en = a[13];
        s.two_speed_switchover_en = a[12];
        s.clock_out_drive = !a[11];
        s.brownout_mode = cwd_sup_t'(a[10:9]);
        s.code_protect_on = !a[7];
        s.reset_pin_is_reset = b[13] | a[6];
        s.powerup_timer_on = !a[5];
        s.watchdog_mode = cwd_sup_t'(a[4:3]);
        s.osc_sel = cwd_osc_t'(a[2:0]);
        s.low_voltage_prog_en = b[13];
        s.debugger_on = !b[12];
        s.low_power_brownout_on = !b[11];
        s.brownout_trip_low = b[10];
        s.stack_fault_reset_en = b[9];
        s.pll_on = b[8];
        s.pll_factor = b[7] ? 3'h3 : 3'h4;
        s.usb_clock_div = b[6] ? 4'h8 : 4'h4;
        s.cpu_clock_div = b[5] ? (b[4] ? 3'h6 : 3'h3) : (b[4] ? 3'h2 : 3'h1);
        s.self_write_protect_field = b[1:0];
        return s;
    endfunction
    // one strobe cycle, then settle past the answer edge
    task automatic bus(input logic [15:0] a, input logic [13:0] d, input logic w, input logic e);
        @(posedge clk);
        req <= '{a, d, w, !w, e};
        @(posedge clk);
        req <= '0;
        #1;
    endtask
    task automatic rd(input logic [15:0] a, input logic e, input logic [13:0] x);
        bus(a, 14'h0000, 1'b0, e);
        `CHK(rdata, x)
    endtask
    task automatic wr(input logic [15:0] a, input logic [13:0] d, input logic e, input logic g);
        bus(a, d, 1'b1, e);
        `CHK(pm_wr, g)
        if (g)
        begin
            `CHK(pm_addr, a[14:0])
            `CHK(pm_wdata, d)
        end
    endtask
    task automatic do_reset(input logic [13:0] c1, input logic [13:0] c2);
        @(posedge clk);
        rst_n <= 1'b0;
        nv1 <= c1;
        nv2 <= c2;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
        img1 = c1 | 14'h0100;
        img2 = c2 | 14'h000C;
    endtask
    initial
    begin
        logic [13:0] c1, c2;
        logic [15:0] a, lim;
        logic p;
        // every field code at least once, the rest random
        for (int i = 0; i < 8; i++)
        begin
            c1 = rnd();
            c2 = rnd();
            {c1[2:0], c1[10:9], c1[4:3], c1[7]} = {3'(i), 2'(i), ~2'(i), i[2]};
            {c2[13], c2[5:4], c2[1:0]} = {i[0], 2'(i), 2'(i)};
            do_reset(c1, c2);
            `CHK(loaded, 1'b1)
            `CHK(settings, exp_set(c1, c2))
            rd(16'h8007, 1'b1, img1);
            rd(16'h8008, 1'b1, img2);
            rd(16'h8005, 1'b1, PART);
            wr(16'h8006, rnd(), 1'b1, 1'b0);
            rd(16'h8006, 1'b0, REV);
            rd(16'h8004, 1'b1, 14'h0000);
            p = !c1[7];
            a = {2'b00, rnd()};
            rd(a, 1'b1, p ? 14'h0000 : pm_val(a[14:0]));
            rd(a, 1'b0, pm_val(a[14:0]));
            wr(a, rnd(), 1'b1, !p);
            lim = c2[1] ? 16'h01FF : (c2[0] ? 16'h0FFF : 16'h1FFF);
            if (c2[1:0] != 2'h3)
            begin
                wr(lim, rnd(), 1'b0, 1'b0);
                wr(lim + 16'h0001, rnd(), 1'b0, 1'b1);
            end
            else
                wr(16'h0000, rnd(), 1'b0, 1'b1);
            for (int k = 0; k < 4; k++)
            begin
                uid[k] = rnd();
                wr(16'h8000 + 16'(k), uid[k], 1'b0, 1'b0);
            end
            for (int k = 0; k < 4; k++)
                rd(16'h8000 + 16'(k), 1'b0, uid[k]);
        end
        // sticky protect bit, low-voltage lock, bulk erase
        do_reset(14'h3FFF, 14'h3FFF);
        wr(16'h8007, 14'h3F7F, 1'b1, 1'b0);
        rd(16'h8007, 1'b1, 14'h3F7F);
        wr(16'h8007, 14'h3FFF, 1'b1, 1'b0);
        rd(16'h8007, 1'b1, 14'h3F7F);
        wr(16'h8008, 14'h0000, 1'b0, 1'b0);
        rd(16'h8008, 1'b1, 14'h3FFF);
        @(posedge clk) lvp_entry <= 1'b1;
        wr(16'h8008, 14'h1FFF, 1'b1, 1'b0);
        rd(16'h8008, 1'b1, 14'h3FFF);
        @(posedge clk) lvp_entry <= 1'b0;
        wr(16'h8008, 14'h1FF3, 1'b1, 1'b0);
        rd(16'h8008, 1'b1, 14'h1FFF);
        @(posedge clk) erase <= 1'b1;
        @(posedge clk) erase <= 1'b0;
        rd(16'h8007, 1'b1, 14'h3FFF);
        `CHK(settings, exp_set(14'h3FFF, 14'h3FFF))
        // clock enable low: a user word write must be frozen out
        @(posedge clk) ce <= 1'b0;
        wr(16'h8000, 14'h0123, 1'b1, 1'b0);
        @(posedge clk) ce <= 1'b1;
        rd(16'h8000, 1'b1, 14'h3FFF);
        print_verdict;
    end
endmodule
`default_nettype wire
